// ===== rtl/bst_tap.sv
`timescale 1ns/1ps
// What this block does
// - sixteen-state synchronous test access controller
// - transitions follow tms at each tck rise
// - data enters from tdi, leaves on tdo
// - separate data and instruction scan branches
// - instruction picks test and data register
// - decode extest, sample, idcode, bypass, clamp, highz
// - one-bit bypass path from tdi to tdo
// - ident word: version, part, maker, fixed bit
// - two cells per pin: observe, control+observe
module bst_tap (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_q,
  output logic tdo_oe_q,
  input wire logic [bst_pkg::PIN_CNT-1:0] pin_in,
  output logic [bst_pkg::PIN_CNT-1:0] pin_out_q,
  output logic [bst_pkg::PIN_CNT-1:0] pin_oe_q,
  input wire logic [bst_pkg::PIN_CNT-1:0] core_out,
  input wire logic [bst_pkg::PIN_CNT-1:0] core_oe,
  output logic [bst_pkg::PIN_CNT-1:0] core_in_q
);
  import bst_pkg::*;

  ////////////////////////////////////////////////////////////////
  // synchronisers; tck, tms, tdi share depth so they stay aligned
  logic tck_s1_q, tck_s2_q, tck_s3_q;
  logic tms_s1_q, tms_s2_q;
  logic tdi_s1_q, tdi_s2_q;
  logic [PIN_CNT-1:0] pin_s1_q, pin_s2_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {tck_s1_q, tck_s2_q, tck_s3_q} <= '0;
      {tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q} <= '0;
      {pin_s1_q, pin_s2_q} <= '0;
    end else begin
      {tck_s1_q, tck_s2_q, tck_s3_q} <= {tck, tck_s1_q, tck_s2_q};
      {tms_s1_q, tms_s2_q} <= {tms, tms_s1_q};
      {tdi_s1_q, tdi_s2_q} <= {tdi, tdi_s1_q};
      {pin_s1_q, pin_s2_q} <= {pin_in, pin_s1_q};
    end
  end

  wire tck_rise = tck_s2_q & ~tck_s3_q;
  wire tck_fall = ~tck_s2_q & tck_s3_q;

  ////////////////////////////////////////////////////////////////
  // controller
  bst_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_TLR: state_d = tms_s2_q ? ST_TLR : ST_RTI;
      ST_RTI: state_d = tms_s2_q ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_d = tms_s2_q ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms_s2_q ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_d = tms_s2_q ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_d = tms_s2_q ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_d = tms_s2_q ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_d = tms_s2_q ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_d = tms_s2_q ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_d = tms_s2_q ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_d = tms_s2_q ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_d = tms_s2_q ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_d = tms_s2_q ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_d = tms_s2_q ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_d = tms_s2_q ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_d = tms_s2_q ? ST_SEL_DR : ST_RTI;
      default: state_d = ST_TLR;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_TLR;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // action strobes: capture/shift on the rise leaving the state, update on the fall inside it
  wire cap_dr = tck_rise & (state_q == ST_CAP_DR);
  wire sh_dr = tck_rise & (state_q == ST_SH_DR);
  wire upd_dr = tck_fall & (state_q == ST_UPD_DR);
  wire cap_ir = tck_rise & (state_q == ST_CAP_IR);
  wire sh_ir = tck_rise & (state_q == ST_SH_IR);
  wire upd_ir = tck_fall & (state_q == ST_UPD_IR);
  wire in_tlr = state_q == ST_TLR;
  wire shifting = (state_q == ST_SH_DR) | (state_q == ST_SH_IR);

  ////////////////////////////////////////////////////////////////
  // instruction register and decode
  logic [IR_LEN-1:0] ir_sh_q, ir_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ir_sh_q <= IR_CAPT;
    end else if (cap_ir) begin
      ir_sh_q <= IR_CAPT;
    end else if (sh_ir) begin
      ir_sh_q <= {tdi_s2_q, ir_sh_q[IR_LEN-1:1]};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ir_q <= INS_IDCODE;
    end else if (in_tlr) begin
      ir_q <= INS_IDCODE;
    end else if (upd_ir) begin
      ir_q <= ir_sh_q;
    end
  end

  wire dec_extest = ir_q == INS_EXTEST;
  wire dec_sample = ir_q == INS_SAMPLE;
  wire dec_idcode = ir_q == INS_IDCODE;
  wire dec_clamp = ir_q == INS_CLAMP;
  wire dec_highz = ir_q == INS_HIGHZ;
  // clamp, highz and unknown codes all route through bypass
  wire sel_bsc = dec_extest | dec_sample;
  wire sel_id = dec_idcode;
  wire drive_cells = dec_extest | dec_clamp;

  ////////////////////////////////////////////////////////////////
  // data registers
  logic single_bit_passthrough_q;
  logic [ID_LEN-1:0] ident_word_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      single_bit_passthrough_q <= PASS_CAPT;
    end else if (cap_dr) begin
      single_bit_passthrough_q <= PASS_CAPT;
    end else if (sh_dr) begin
      single_bit_passthrough_q <= tdi_s2_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ident_word_q <= ID_WORD;
    end else if (cap_dr & sel_id) begin
      ident_word_q <= ID_WORD;
    end else if (sh_dr & sel_id) begin
      ident_word_q <= {tdi_s2_q, ident_word_q[ID_LEN-1:1]};
    end
  end

  wire chain_so;
  wire [PIN_CNT-1:0] chain_upd;

  bst_cell_chain u_scan_cell_chain (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .cap_en(cap_dr & sel_bsc),
    .shift_en(sh_dr & sel_bsc),
    .upd_en(upd_dr & sel_bsc),
    .si(tdi_s2_q),
    .pin_obs(pin_s2_q),
    .core_obs(core_out),
    .so(chain_so),
    .upd_out(chain_upd)
  );

  ////////////////////////////////////////////////////////////////
  // tdo: changes on falling tck, released outside shift states
  wire dr_lsb = sel_id ? ident_word_q[0] : (sel_bsc ? chain_so : single_bit_passthrough_q);
  wire tdo_src = (state_q == ST_SH_IR) ? ir_sh_q[0] : dr_lsb;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q <= tdo_src;
      tdo_oe_q <= shifting;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin muxing; adds one clock of latency on the functional path
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      core_in_q <= '0;
    end else begin
      pin_out_q <= drive_cells ? chain_upd : core_out;
      pin_oe_q <= dec_highz ? '0 : (drive_cells ? '1 : core_oe);
      core_in_q <= pin_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic [2:0] ones_cnt_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ones_cnt_q <= '0;
    end else if (tck_rise) begin
      ones_cnt_q <= tms_s2_q ? ((ones_cnt_q == 3'(TLR_ONES)) ? ones_cnt_q : ones_cnt_q + 3'h1) : '0;
    end
  end

  sequence s_rise_tms_hi;
    tck_rise && tms_s2_q;
  endsequence
  sequence s_ir_loaded;
    tck_fall && state_q == ST_UPD_IR;
  endsequence

  a_five_ones_reset: assert property (s_rise_tms_hi and ones_cnt_q == 3'(TLR_ONES - 1) |=> state_q == ST_TLR)
    else $error("five tms-high rises did not reach reset");
  a_tlr_leave: assert property (tck_rise && !tms_s2_q && in_tlr |=> state_q == ST_RTI)
    else $error("reset state not left on tms low");
  a_state_hold: assert property (!tck_rise |=> $stable(state_q))
    else $error("state moved without tck rise");
  a_bypass_shift: assert property (sh_dr && !sel_id && !sel_bsc |=> single_bit_passthrough_q == $past(tdi_s2_q))
    else $error("bypass bit did not take tdi");
  a_ir_capture: assert property (cap_ir |=> ir_sh_q == IR_CAPT)
    else $error("instruction capture pattern wrong");
  a_ir_update: assert property (s_ir_loaded |=> ir_q == $past(ir_sh_q))
    else $error("instruction not updated");
  a_id_capture: assert property (cap_dr && sel_id |=> ident_word_q == ID_WORD)
    else $error("ident word not captured");
  a_tdo_release: assert property (tck_fall && !shifting |=> !tdo_oe_q)
    else $error("tdo driven outside shift");
  a_tdo_follow: assert property (tck_fall && state_q == ST_SH_DR |=> tdo_oe_q && tdo_q == $past(dr_lsb))
    else $error("tdo did not present register bit");
  a_highz_pins: assert property (dec_highz ##1 dec_highz |=> pin_oe_q == '0)
    else $error("pins driven under highz");

endmodule : bst_tap

// ===== rtl/bst_pkg.sv
package bst_pkg;

  // scan geometry
  localparam int PIN_CNT = 4;
  localparam int CHAIN_LEN = 2 * PIN_CNT;
  localparam int IR_LEN = 4;
  localparam int ID_LEN = 32;

  // instruction codes; all-ones is bypass, unknown codes fall back to bypass
  localparam logic [IR_LEN-1:0] INS_EXTEST = 4'h0;
  localparam logic [IR_LEN-1:0] INS_SAMPLE = 4'h1;
  localparam logic [IR_LEN-1:0] INS_IDCODE = 4'h2;
  localparam logic [IR_LEN-1:0] INS_CLAMP = 4'h3;
  localparam logic [IR_LEN-1:0] INS_HIGHZ = 4'h4;
  localparam logic [IR_LEN-1:0] INS_BYPASS = 4'hf;
  localparam logic [IR_LEN-1:0] IR_CAPT = 4'h1;

  // ident word fields; values are arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h0a5c;
  localparam logic [10:0] ID_MAKER = 11'h123;
  localparam logic ID_FIXED = 1'b1;
  localparam logic [ID_LEN-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED};

  localparam logic PASS_CAPT = 1'b0;
  localparam int TLR_ONES = 5;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_state_t;

endpackage : bst_pkg

// ===== rtl/bst_cell_chain.sv
`timescale 1ns/1ps
module bst_cell_chain (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cap_en,
  input wire logic shift_en,
  input wire logic upd_en,
  input wire logic si,
  input wire logic [bst_pkg::PIN_CNT-1:0] pin_obs,
  input wire logic [bst_pkg::PIN_CNT-1:0] core_obs,
  output logic so,
  output logic [bst_pkg::PIN_CNT-1:0] upd_out
);
  import bst_pkg::*;

  logic [CHAIN_LEN-1:0] cell_q;
  logic [CHAIN_LEN-1:0] cell_d;
  logic [CHAIN_LEN-1:0] par_in;
  logic [CHAIN_LEN:0] ser_in;

  assign ser_in[CHAIN_LEN] = si;
  assign ser_in[CHAIN_LEN-1:0] = cell_q;
  assign so = cell_q[0];

  ////////////////////////////////////////////////////////////////
  // per pin: even cell observes the pin, odd cell drives it
  genvar k;
  generate
    for (k = 0; k < PIN_CNT; k++) begin : g_pin
      assign par_in[2*k] = pin_obs[k];
      assign par_in[2*k+1] = core_obs[k];
      // only the out cell has an update latch
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          upd_out[k] <= 1'b0;
        end else if (upd_en) begin
          upd_out[k] <= cell_q[2*k+1];
        end
      end
    end
    for (k = 0; k < CHAIN_LEN; k++) begin : g_cell
      assign cell_d[k] = shift_en ? ser_in[k+1] : (cap_en ? par_in[k] : cell_q[k]);
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cell_q <= '0;
    end else begin
      cell_q <= cell_d;
    end
  end

  a_cell_shift: assert property (@(posedge clk_sys) disable iff (!rstn)
    shift_en |=> cell_q[CHAIN_LEN-1] == $past(si))
    else $error("chain top did not take serial input");
  a_out_update: assert property (@(posedge clk_sys) disable iff (!rstn)
    upd_en |=> upd_out[0] == $past(cell_q[1]))
    else $error("out cell update latch did not load");

endmodule : bst_cell_chain

// ===== tb/bst_tester.sv
`timescale 1ns/1ps
module bst_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_q,
  input wire logic tdo_oe_q
);
  logic oe_all;
  logic oe_seen;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    oe_all = 1'b1;
  end

  ////////////////////////////////////////////////////////////
  // one tck period; tck rests low between frames
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62.5;
    // released tdo has no pull, so show the inverse of the last bit
    o = tdo_oe_q ? tdo_q : ~tdo_q;
    oe_seen = tdo_oe_q;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask : step

  task automatic tlr();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : tlr

  // from idle, scan n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    oe_all = 1'b1;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
      // only shift-state samples count; exit states release tdo
      oe_all = oe_all & oe_seen;
    end
    // tdi flips after use so a stale level is never mistaken for data
    step(1'b1, ~din[n-1], o);
    step(1'b0, din[n-1], o);
  endtask : scan
endmodule : bst_tester

// ===== tb/bst_tap_tb.sv
`timescale 1ns/1ps
module bst_tap_tb;
  import bst_pkg::*;
  typedef struct packed {
    logic [IR_LEN-1:0] ins;
    logic [5:0] len;
    logic [31:0] din;
    logic [31:0] dout;
    logic [PIN_CNT-1:0] pout;
    logic [PIN_CNT-1:0] poe;
  } bst_row_t;

  logic clk_sys, rstn, tck, tms, tdi, tdo_q, tdo_oe_q;
  logic [PIN_CNT-1:0] pin_in, pin_out_q, pin_oe_q, core_out, core_oe, core_in_q;
  logic [31:0] got;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;

  // pin_in 4'ha and core_out 4'h6 make the captured chain 8'h6c
  bst_row_t rows [7] = '{
    '{INS_IDCODE, 6'd32, 32'h0, ID_WORD, 4'h6, 4'h5},
    '{INS_SAMPLE, 6'd8, 32'ha2, 32'h6c, 4'h6, 4'h5},
    '{INS_EXTEST, 6'd8, 32'h08, 32'h6c, 4'h2, 4'hf},
    '{INS_CLAMP, 6'd8, 32'hb1, 32'h62, 4'h2, 4'hf},
    '{INS_HIGHZ, 6'd8, 32'h0f, 32'h1e, 4'h6, 4'h0},
    '{INS_BYPASS, 6'd8, 32'h81, 32'h02, 4'h6, 4'h5},
    '{4'h9, 6'd8, 32'h7e, 32'hfc, 4'h6, 4'h5}
  };

  bst_tap bst_tap_inst (.clk_sys(clk_sys), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo_q),
    .tdo_oe_q(tdo_oe_q), .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .core_out(core_out),
    .core_oe(core_oe), .core_in_q(core_in_q));

  bst_tester bst_tester_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got_v);
    tests_run++;
    if (got_v !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got_v);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic settle();
    repeat (8) @(posedge clk_sys);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // run needs about 7500 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    rstn = 1'b0;
    pin_in = 4'ha;
    core_out = 4'h6;
    core_oe = 4'h5;
    repeat (10) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    settle();
    bst_tester_inst.tlr();
    foreach (rows[k]) begin
      bst_tester_inst.scan(1'b1, IR_LEN, 32'(rows[k].ins), got);
      chk("ir capture", 32'(IR_CAPT), got);
      bst_tester_inst.scan(1'b0, int'(rows[k].len), rows[k].din, got);
      chk("dr out", rows[k].dout, got);
      chk("tdo enable", 32'h1, 32'(bst_tester_inst.oe_all));
      settle();
      chk("pin enable", 32'(rows[k].poe), 32'(pin_oe_q));
      chk("pin out", 32'(rows[k].pout), 32'(pin_out_q));
      chk("tdo idle", 32'h0, 32'(tdo_oe_q));
    end
    // abandon a bypass shift midway; five ones must still reach reset
    bst_tester_inst.scan(1'b1, IR_LEN, 32'(INS_BYPASS), got);
    bst_tester_inst.step(1'b1, 1'b1, got[0]);
    repeat (3) bst_tester_inst.step(1'b0, 1'b1, got[0]);
    bst_tester_inst.tlr();
    bst_tester_inst.scan(1'b0, ID_LEN, 32'h0, got);
    chk("ident after tms reset", ID_WORD, got);
    // reset in mid-run with extest active
    bst_tester_inst.scan(1'b1, IR_LEN, 32'(INS_EXTEST), got);
    settle();
    chk("extest enable", 32'hf, 32'(pin_oe_q));
    rstn = 1'b0;
    settle();
    chk("pin enable in reset", 32'h0, 32'(pin_oe_q));
    rstn = 1'b1;
    settle();
    // reset leaves the controller in test logic reset; step to idle first
    bst_tester_inst.step(1'b0, 1'b0, got[0]);
    bst_tester_inst.scan(1'b0, ID_LEN, 32'h0, got);
    chk("ident after reset", ID_WORD, got);
    settle();
    chk("pin enable after reset", 32'h5, 32'(pin_oe_q));
    pin_in = 4'h3;
    settle();
    chk("core in", 32'h3, 32'(core_in_q));
    end_sim();
  end
endmodule : bst_tap_tb
